// file: src/fsp_defines.svh
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

// ==========================================================
// Instruction opcodes seen by this block
`define FSP_OP_SUSPEND   8'h75
`define FSP_OP_RESUME    8'h7A
`define FSP_OP_ENTER_QPI 8'h38
`define FSP_OP_EXIT_QPI  8'hFF

// ==========================================================
// Status register two field positions (bit within byte)
`define FSP_S2_SUSPEND  7
`define FSP_S2_INVERT   6
`define FSP_S2_LOCK3    5
`define FSP_S2_LOCK2    4
`define FSP_S2_LOCK1    3
`define FSP_S2_QUAD_EN  1

// ==========================================================
// Status register three field positions
`define FSP_S3_PIN_SEL  7
`define FSP_S3_DRV_HI   6
`define FSP_S3_DRV_LO   5
`define FSP_S3_SCHEME   2

// ==========================================================
// Reset values
`define FSP_RST_DRIVE   2'h3
`define FSP_RST_QUAD_EN 1'h0
`define FSP_RST_LOCKS   3'h0

// ==========================================================
// Array geometry
`define FSP_ARRAY_LAST  21'h1FFFFF
`define FSP_ARRAY_SIZE  22'h200000
`define FSP_BLOCK_SIZE  21'h010000
`define FSP_SECTOR_SIZE 21'h001000
`define FSP_NUM_LOCKS   62
`define FSP_SECREG_SIZE 9'h100

// ==========================================================
// Drive strength in percent
`define FSP_DRV_PCT_00  7'h64
`define FSP_DRV_PCT_01  7'h4B
`define FSP_DRV_PCT_10  7'h32
`define FSP_DRV_PCT_11  7'h19

`endif

// file: src/fsp_pkg.sv
// ==========================================================
// Shared types
package fsp_pkg;

	// Status register write from the instruction decoder
	typedef struct packed {
		logic       sel_three;
		logic [7:0] data;
	} fsp_wr_t;

	// Erase or program target range, both ends inclusive
	typedef struct packed {
		logic [20:0] first;
		logic [20:0] last;
	} fsp_ep_t;

	// Protected address range
	typedef struct packed {
		logic        none;
		logic [20:0] lo;
		logic [20:0] hi;
	} fsp_range_t;

	// Interface mode
	typedef enum logic {
		FSP_SPI = 1'b0,
		FSP_QPI = 1'b1
	} fsp_mode_t;

endpackage : fsp_pkg

// file: src/fsp_sync2.sv
`timescale 1ns/10ps
`include "fsp_defines.svh"

// ==========================================================
// Two flip-flop synchroniser
module fsp_sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         reset,
	// Data
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	// Next values; pins idle high
	always_comb
	begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	// Register stages
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			meta_q <= '1;
			sync_q <= '1;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule : fsp_sync2

// file: src/fsp_prot_decode.sv
`timescale 1ns/10ps
`include "fsp_defines.svh"

// ==========================================================
// Block-protect field to protected range
module fsp_prot_decode (
	// Protect fields
	input  wire logic       protect_invert,
	input  wire logic       sector_granularity,
	input  wire logic       bottom_select,
	input  wire logic [2:0] protect_level,
	// Result
	output fsp_pkg::fsp_range_t range
);

	logic [21:0] size;
	logic        all;

	// Size of the base region
	always_comb
	begin
		all  = 1'b0;
		size = 22'h000000;
		if (protect_level[2:1] == 2'h3)
			all = 1'b1;
		else if (!sector_granularity)
			size = {1'b0, `FSP_BLOCK_SIZE} << (protect_level - 3'h1);
		else if (protect_level[2])
			size = {1'b0, `FSP_SECTOR_SIZE} << 3;
		else
			size = {1'b0, `FSP_SECTOR_SIZE} << (protect_level - 3'h1);
	end

	// Place region at top or bottom, then invert when asked
	always_comb
	begin
		range.none = 1'b0;
		range.lo   = 21'h000000;
		range.hi   = `FSP_ARRAY_LAST;
		if (protect_level == 3'h0)
			range.none = !protect_invert;
		else if (all)
			range.none = protect_invert;
		else if (!bottom_select)
		begin
			if (protect_invert)
				range.hi = 21'(`FSP_ARRAY_SIZE - size - 22'h1);
			else
				range.lo = 21'(`FSP_ARRAY_SIZE - size);
		end
		else
		begin
			if (protect_invert)
				range.lo = 21'(size);
			else
				range.hi = 21'(size - 22'h1);
		end
	end

endmodule : fsp_prot_decode

// file: src/fsp_status_protect.sv
`timescale 1ns/10ps
`include "fsp_defines.svh"


// ==========================================================
// Status registers two and three with array write protection
module fsp_status_protect (
	// Clock and reset
	input  wire logic               core_clk,
	input  wire logic               reset,
	// Decoded instruction opcode, one-cycle strobe
	input  wire logic               cmd_valid,
	input  wire logic [7:0]         cmd_opcode,
	// Status register write, already permitted by status one logic
	input  wire logic               sr_wr_valid,
	input  wire fsp_pkg::fsp_wr_t   sr_wr,
	// Protect fields held in status register one
	input  wire logic               sector_granularity,
	input  wire logic               bottom_select,
	input  wire logic [2:0]         protect_level,
	// Individual lock commands
	input  wire logic               lock_one,
	input  wire logic               unlock_one,
	input  wire logic               lock_all,
	input  wire logic               unlock_all,
	input  wire logic [20:0]        lock_addr,
	// Erase or program request
	input  wire logic               ep_valid,
	input  wire fsp_pkg::fsp_ep_t   ep_req,
	// Security register erase or program request
	input  wire logic               sec_valid,
	input  wire logic [1:0]         sec_index,
	// Shared pins, active low, asynchronous
	input  wire logic               wp_pin_n,
	input  wire logic               pause_reset_pin_n,
	// Register read values
	output logic [7:0]              status_two,
	output logic [7:0]              status_three,
	// Mode and pin function
	output logic                    quad_command_mode,
	output logic                    quad_data_pins,
	output logic                    write_protect_active,
	output logic                    pause_active,
	output logic                    pin_reset_req,
	// Drive strength
	output logic [1:0]              drive_code,
	output logic [6:0]              drive_pct,
	// Array request answer, one-cycle pulses
	output logic                    ep_accept,
	output logic                    ep_reject,
	// Security register answer, one-cycle pulses
	output logic                    sec_accept,
	output logic                    sec_reject
);

	// ==========================================================
	// Declarations
	logic                     suspend_flag_q, suspend_flag_d;
	logic                     protect_invert_q, protect_invert_d;
	logic [2:0]               otp_lock_q, otp_lock_d;
	logic                     quad_io_enable_q, quad_io_enable_d;
	logic                     pin_select_q, pin_select_d;
	logic [1:0]               drive_q, drive_d;
	logic                     protect_scheme_select_q, protect_scheme_select_d;
	fsp_pkg::fsp_mode_t       mode_q, mode_d;
	logic [`FSP_NUM_LOCKS-1:0] blk_lock_q, blk_lock_d;
	logic [6:0]               drive_pct_q, drive_pct_d;
	logic                     ep_accept_q, ep_accept_d;
	logic                     ep_reject_q, ep_reject_d;
	logic                     sec_accept_q, sec_accept_d;
	logic                     sec_reject_q, sec_reject_d;
	logic [1:0]               pin_sync;
	fsp_pkg::fsp_range_t      range;
	logic                     range_hit;
	logic                     lock_hit;
	logic                     sec_locked;
	logic [5:0]               lock_idx;

	// Lock index of an address: sectors of block 0, blocks 1..30, sectors of block 31
	function automatic logic [5:0] fsp_lock_index(input logic [20:0] addr);
		logic [4:0] blk;
		blk = addr[20:16];
		if (blk == 5'h00)
			fsp_lock_index = {2'h0, addr[15:12]};
		else if (blk == 5'h1F)
			fsp_lock_index = 6'(6'd46 + {2'h0, addr[15:12]});
		else
			fsp_lock_index = 6'(6'd15 + {1'b0, blk});
	endfunction : fsp_lock_index

	// ==========================================================
	// Pin synchronisers
	fsp_sync2 #(
		.W (2)
	) u_pin_sync (
		.core_clk (core_clk),
		.reset    (reset),
		.async_in ({wp_pin_n, pause_reset_pin_n}),
		.sync_out (pin_sync)
	);

	// ==========================================================
	// Range protection decode
	fsp_prot_decode u_prot_decode (
		.protect_invert     (protect_invert_q),
		.sector_granularity (sector_granularity),
		.bottom_select      (bottom_select),
		.protect_level      (protect_level),
		.range              (range)
	);

	// ==========================================================
	// Protection checks against the whole target range
	always_comb
	begin
		logic [20:0] lo;
		logic [20:0] hi;
		lo = 21'h000000;
		hi = 21'h000000;
		range_hit = !range.none && (ep_req.first <= range.hi) && (ep_req.last >= range.lo);
		lock_hit  = 1'b0;
		for (int i = 0; i < `FSP_NUM_LOCKS; i++)
		begin
			if (i < 16)
			begin
				lo = 21'(i) << 12;
				hi = lo + `FSP_SECTOR_SIZE - 21'h1;
			end
			else if (i < 46)
			begin
				lo = 21'(i - 15) << 16;
				hi = lo + `FSP_BLOCK_SIZE - 21'h1;
			end
			else
			begin
				lo = 21'h1F0000 + (21'(i - 46) << 12);
				hi = lo + `FSP_SECTOR_SIZE - 21'h1;
			end
			if (blk_lock_q[i] && ep_req.first <= hi && ep_req.last >= lo)
				lock_hit = 1'b1;
		end
	end

	// Security register lock lookup, index 1..3
	always_comb
	begin
		sec_locked = 1'b1;
		if (sec_index != 2'h0)
			sec_locked = otp_lock_q[sec_index - 2'h1];
	end

	// ==========================================================
	// Status register two next values
	always_comb
	begin
		suspend_flag_d   = suspend_flag_q;
		protect_invert_d = protect_invert_q;
		otp_lock_d       = otp_lock_q;
		quad_io_enable_d = quad_io_enable_q;
		if (cmd_valid && cmd_opcode == `FSP_OP_RESUME)
			suspend_flag_d = 1'b0;
		if (cmd_valid && cmd_opcode == `FSP_OP_SUSPEND)
			suspend_flag_d = 1'b1;
		if (sr_wr_valid && !sr_wr.sel_three)
		begin
			protect_invert_d = sr_wr.data[`FSP_S2_INVERT];
			// One-time bits only ever set
			otp_lock_d[2] = otp_lock_q[2] | sr_wr.data[`FSP_S2_LOCK3];
			otp_lock_d[1] = otp_lock_q[1] | sr_wr.data[`FSP_S2_LOCK2];
			otp_lock_d[0] = otp_lock_q[0] | sr_wr.data[`FSP_S2_LOCK1];
			// Held at 1 while in quad command mode
			quad_io_enable_d = sr_wr.data[`FSP_S2_QUAD_EN] | (mode_q == fsp_pkg::FSP_QPI);
		end
	end

	// Status register three next values
	always_comb
	begin
		pin_select_d            = pin_select_q;
		drive_d                 = drive_q;
		protect_scheme_select_d = protect_scheme_select_q;
		if (sr_wr_valid && sr_wr.sel_three)
		begin
			pin_select_d            = sr_wr.data[`FSP_S3_PIN_SEL];
			drive_d                 = {sr_wr.data[`FSP_S3_DRV_HI], sr_wr.data[`FSP_S3_DRV_LO]};
			protect_scheme_select_d = sr_wr.data[`FSP_S3_SCHEME];
		end
	end

	// Command mode next value
	always_comb
	begin
		mode_d = mode_q;
		unique case (mode_q)
			fsp_pkg::FSP_SPI:
				if (cmd_valid && cmd_opcode == `FSP_OP_ENTER_QPI && quad_io_enable_q)
					mode_d = fsp_pkg::FSP_QPI;
			fsp_pkg::FSP_QPI:
				if (cmd_valid && cmd_opcode == `FSP_OP_EXIT_QPI)
					mode_d = fsp_pkg::FSP_SPI;
		endcase
	end

	// Individual lock bits next values
	always_comb
	begin
		lock_idx   = fsp_lock_index(lock_addr);
		blk_lock_d = blk_lock_q;
		if (unlock_all)
			blk_lock_d = '0;
		else if (lock_all)
			blk_lock_d = '1;
		else if (unlock_one)
			blk_lock_d[lock_idx] = 1'b0;
		else if (lock_one)
			blk_lock_d[lock_idx] = 1'b1;
	end

	// Answers and drive decode next values
	always_comb
	begin
		ep_accept_d  = 1'b0;
		ep_reject_d  = 1'b0;
		sec_accept_d = 1'b0;
		sec_reject_d = 1'b0;
		if (ep_valid)
		begin
			if (protect_scheme_select_q)
				ep_reject_d = lock_hit;
			else
				ep_reject_d = range_hit;
			ep_accept_d = !ep_reject_d;
		end
		if (sec_valid)
		begin
			sec_reject_d = sec_locked;
			sec_accept_d = !sec_locked;
		end
		unique case (drive_q)
			2'h0: drive_pct_d = `FSP_DRV_PCT_00;
			2'h1: drive_pct_d = `FSP_DRV_PCT_01;
			2'h2: drive_pct_d = `FSP_DRV_PCT_10;
			2'h3: drive_pct_d = `FSP_DRV_PCT_11;
		endcase
	end

	// ==========================================================
	// State registers
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			suspend_flag_q          <= 1'b0;
			protect_invert_q        <= 1'b0;
			otp_lock_q              <= `FSP_RST_LOCKS;
			quad_io_enable_q        <= `FSP_RST_QUAD_EN;
			pin_select_q            <= 1'b0;
			drive_q                 <= `FSP_RST_DRIVE;
			protect_scheme_select_q <= 1'b0;
			mode_q                  <= fsp_pkg::FSP_SPI;
			blk_lock_q              <= '1;
			drive_pct_q             <= `FSP_DRV_PCT_11;
			ep_accept_q             <= 1'b0;
			ep_reject_q             <= 1'b0;
			sec_accept_q            <= 1'b0;
			sec_reject_q            <= 1'b0;
		end
		else
		begin
			suspend_flag_q          <= suspend_flag_d;
			protect_invert_q        <= protect_invert_d;
			otp_lock_q              <= otp_lock_d;
			quad_io_enable_q        <= quad_io_enable_d;
			pin_select_q            <= pin_select_d;
			drive_q                 <= drive_d;
			protect_scheme_select_q <= protect_scheme_select_d;
			mode_q                  <= mode_d;
			blk_lock_q              <= blk_lock_d;
			drive_pct_q             <= drive_pct_d;
			ep_accept_q             <= ep_accept_d;
			ep_reject_q             <= ep_reject_d;
			sec_accept_q            <= sec_accept_d;
			sec_reject_q            <= sec_reject_d;
		end
	end

	// ==========================================================
	// Register read values, reserved bits read zero
	always_comb
	begin
		status_two                    = 8'h00;
		status_two[`FSP_S2_SUSPEND]   = suspend_flag_q;
		status_two[`FSP_S2_INVERT]    = protect_invert_q;
		status_two[`FSP_S2_LOCK3]     = otp_lock_q[2];
		status_two[`FSP_S2_LOCK2]     = otp_lock_q[1];
		status_two[`FSP_S2_LOCK1]     = otp_lock_q[0];
		status_two[`FSP_S2_QUAD_EN]   = quad_io_enable_q;
		status_three                  = 8'h00;
		status_three[`FSP_S3_PIN_SEL] = pin_select_q;
		status_three[`FSP_S3_DRV_HI]  = drive_q[1];
		status_three[`FSP_S3_DRV_LO]  = drive_q[0];
		status_three[`FSP_S3_SCHEME]  = protect_scheme_select_q;
	end

	// Pin functions gated by quad enable
	assign quad_data_pins       = quad_io_enable_q;
	assign write_protect_active = !quad_io_enable_q && !pin_sync[1];
	assign pause_active         = !quad_io_enable_q && !pin_select_q && !pin_sync[0];
	assign pin_reset_req        = !quad_io_enable_q && pin_select_q && !pin_sync[0];

	// Other outputs
	assign quad_command_mode = (mode_q == fsp_pkg::FSP_QPI);
	assign drive_code        = drive_q;
	assign drive_pct         = drive_pct_q;
	assign ep_accept         = ep_accept_q;
	assign ep_reject         = ep_reject_q;
	assign sec_accept        = sec_accept_q;
	assign sec_reject        = sec_reject_q;

endmodule : fsp_status_protect

// file: testbench/fsp_status_protect_asserts.sv
`timescale 1ns/10ps

// ==========================================================
// Port checker for the status and protect block
module fsp_chk (
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       reset,
	// Requests
	input wire logic       cmd_valid,
	input wire logic [7:0] cmd_opcode,
	input wire logic       ep_valid,
	input wire logic       sec_valid,
	input wire logic [1:0] sec_index,
	// Answers
	input wire logic [7:0] status_two,
	input wire logic [7:0] status_three,
	input wire logic       quad_command_mode,
	input wire logic       quad_data_pins,
	input wire logic       write_protect_active,
	input wire logic       pause_active,
	input wire logic       pin_reset_req,
	input wire logic [1:0] drive_code,
	input wire logic [6:0] drive_pct,
	input wire logic       ep_accept,
	input wire logic       ep_reject,
	input wire logic       sec_reject
);
	// Percent for a drive code: 100 less 25 per step
	function automatic logic [6:0] pct(input logic [1:0] c);
		return 7'h64 - 7'h19 * c;
	endfunction : pct

	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	// ==========================================================
	// Assertions
	a_suspend_set: assert property (cmd_valid && cmd_opcode == 8'h75 |=> status_two[7])
		else $error("suspend flag not set");
	a_resume_clear: assert property (cmd_valid && cmd_opcode == 8'h7A |=> !status_two[7])
		else $error("suspend flag not cleared");
	a_locks_stay_set: assert property (!$past(reset) |-> ($past(status_two[5:3]) & ~status_two[5:3]) == 3'h0)
		else $error("lock bit cleared");
	a_qpi_keeps_qe: assert property (quad_command_mode |-> status_two[1])
		else $error("quad mode without quad enable");
	a_qpi_refused: assert property (cmd_valid && cmd_opcode == 8'h38 && !status_two[1] |=> !quad_command_mode)
		else $error("quad mode entered while disabled");
	a_quad_pins: assert property (status_two[1] |-> quad_data_pins && !(write_protect_active || pause_active))
		else $error("pins not given to data");
	a_pin_select: assert property (pause_active |-> !status_three[7] && !status_two[1])
		else $error("pause function wrong");
	a_reset_select: assert property (pin_reset_req |-> status_three[7] && !status_two[1])
		else $error("reset function wrong");
	a_drive_pct: assert property (!$past(reset) |-> drive_pct == pct($past(drive_code)))
		else $error("drive percent wrong");
	a_ep_answer: assert property (ep_valid |=> ep_accept ^ ep_reject)
		else $error("array request not answered once");
	a_ep_quiet: assert property (!ep_valid |=> !ep_accept && !ep_reject)
		else $error("array answer without request");
	a_sec_locked: assert property (sec_valid && (sec_index == 2'h0 || status_two[sec_index + 2]) |=> sec_reject)
		else $error("locked security register written");
	a_reserved_zero: assert property ((status_two & 8'h05) == 8'h00 && (status_three & 8'h1B) == 8'h00)
		else $error("reserved bit set");
endmodule : fsp_chk

bind fsp_status_protect fsp_chk i_fsp_chk (.*);

// file: testbench/fsp_host_model.sv
`timescale 1ns/10ps

// ==========================================================
// Host controller issuing status and array instructions
module fsp_host_model (
	// Clock
	input wire logic         core_clk,
	// Instruction strobe
	output logic             cmd_valid,
	output logic [7:0]       cmd_opcode,
	// Status write
	output logic             sr_wr_valid,
	output fsp_pkg::fsp_wr_t sr_wr,
	// Array request
	output logic             ep_valid,
	output fsp_pkg::fsp_ep_t ep_req
);
	// Idle bus; released fields show their inverse
	initial
	begin
		cmd_valid   = 1'b0;
		cmd_opcode  = 8'h00;
		sr_wr_valid = 1'b0;
		sr_wr       = '0;
		ep_valid    = 1'b0;
		ep_req      = '0;
	end

	// One instruction opcode
	task automatic cmd(input logic [7:0] op);
		@(posedge core_clk);
		#1;
		cmd_valid  = 1'b1;
		cmd_opcode = op;
		@(posedge core_clk);
		#1;
		cmd_valid  = 1'b0;
		cmd_opcode = ~op;
	endtask : cmd

	// One status byte, reserved bits sent as zero
	task automatic wr(input logic sel, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		sr_wr_valid = 1'b1;
		sr_wr       = {sel, d & (sel ? 8'hE4 : 8'hFA)};
		@(posedge core_clk);
		#1;
		sr_wr_valid = 1'b0;
		sr_wr       = ~sr_wr;
	endtask : wr

	// One erase or program range
	task automatic ep(input logic [20:0] f, input logic [20:0] l);
		@(posedge core_clk);
		#1;
		ep_valid = 1'b1;
		ep_req   = {f, l};
		@(posedge core_clk);
		#1;
		ep_valid = 1'b0;
		ep_req   = ~ep_req;
	endtask : ep
endmodule : fsp_host_model

// file: testbench/testbench.sv
`timescale 1ns/10ps

// ==========================================================
// Self-checking bench for the status and protect block
module testbench;
	logic             core_clk, reset, cmd_valid, sr_wr_valid, ep_valid, sec_valid;
	logic             sector_granularity, bottom_select, lock_one, unlock_one, lock_all, unlock_all;
	logic             wp_pin_n, pause_reset_pin_n, quad_command_mode, quad_data_pins;
	logic             write_protect_active, pause_active, pin_reset_req;
	logic             ep_accept, ep_reject, sec_accept, sec_reject;
	logic [7:0]       cmd_opcode, status_two, status_three;
	logic [2:0]       protect_level;
	logic [20:0]      lock_addr;
	logic [1:0]       sec_index, drive_code;
	logic [6:0]       drive_pct;
	fsp_pkg::fsp_wr_t sr_wr;
	fsp_pkg::fsp_ep_t ep_req;
	logic [31:0]      r;
	int               fails, num_checks, f, l;

	fsp_status_protect i_fsp_status_protect (.*);
	fsp_host_model i_fsp_host_model (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
		.sr_wr_valid(sr_wr_valid), .sr_wr(sr_wr), .ep_valid(ep_valid), .ep_req(ep_req));

	// Clock
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	// Verdict
	task automatic end_of_test;
		if (fails == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	// Expected refusal under the level scheme
	function automatic logic exp_rej(input logic inv, g, bot, input logic [2:0] lv, input int f, l);
		int sz, lo, hi;
		sz = (lv == 3'h0) ? 0 : (lv > 3'h5) ? 'h200000 : g ? ('h1000 << (lv > 3'h4 ? 3 : lv - 1)) : ('h10000 << (lv - 1));
		lo = bot ? 0 : 'h200000 - sz;
		hi = lo + sz - 1;
		if (inv)
			return !(sz != 0 && f >= lo && l <= hi);
		return sz != 0 && f <= hi && l >= lo;
	endfunction : exp_rej

	// Array request and its one-cycle answer
	task automatic epc(input int f, l, input logic e);
		i_fsp_host_model.ep(f[20:0], l[20:0]);
		check({ep_accept, ep_reject}, {~e, e});
	endtask : epc

	// Level scheme case
	task automatic prot(input logic inv, g, bot, input logic [2:0] lv, input int f, l);
		i_fsp_host_model.wr(1'b0, {1'b0, inv, 6'h00});
		{sector_granularity, bottom_select, protect_level} = {g, bot, lv};
		epc(f, l, exp_rej(inv, g, bot, lv, f, l));
	endtask : prot

	// Individual lock command pulse
	task automatic strobe(input logic [3:0] w, input logic [20:0] a);
		@(posedge core_clk);
		#1;
		{unlock_all, lock_all, unlock_one, lock_one} = w;
		lock_addr = a;
		@(posedge core_clk);
		#1;
		{unlock_all, lock_all, unlock_one, lock_one} = 4'h0;
		lock_addr = ~a;
	endtask : strobe

	// Security register request
	task automatic sec(input logic [1:0] i, input logic e);
		@(posedge core_clk);
		#1;
		sec_valid = 1'b1;
		sec_index = i;
		@(posedge core_clk);
		#1;
		sec_valid = 1'b0;
		sec_index = ~i;
		check({sec_accept, sec_reject}, {~e, e});
	endtask : sec

	// Watchdog
	initial
	begin
		repeat (8000) @(posedge core_clk);
		fails++;
		end_of_test;
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		r = 32'h1140;
		{reset, sec_valid, sec_index, wp_pin_n, pause_reset_pin_n} = 6'h23;
		{sector_granularity, bottom_select, protect_level, lock_addr} = '0;
		{unlock_all, lock_all, unlock_one, lock_one} = 4'h0;
		repeat (6) @(posedge core_clk);
		#1;
		reset = 1'b0;
		check({status_two, status_three, drive_pct, quad_command_mode}, {16'h0060, 7'h19, 1'b0});
		i_fsp_host_model.cmd(8'h75);
		check(status_two, 8'h80);
		i_fsp_host_model.wr(1'b0, 8'h00);
		check(status_two, 8'h80);
		i_fsp_host_model.cmd(8'h7A);
		check(status_two, 8'h00);
		for (int d = 0; d < 4; d++)
		begin
			i_fsp_host_model.wr(1'b1, {1'b0, d[1:0], 5'h00});
			@(posedge core_clk);
			#1;
			check({drive_code, drive_pct}, {d[1:0], 7'h64 - 7'h19 * d[6:0]});
		end
		i_fsp_host_model.cmd(8'h38);
		check(quad_command_mode, 1'b0);
		{wp_pin_n, pause_reset_pin_n} = 2'h0;
		repeat (3) @(posedge core_clk);
		#1;
		check({write_protect_active, pause_active, pin_reset_req}, 3'h6);
		i_fsp_host_model.wr(1'b1, 8'h80);
		check({write_protect_active, pause_active, pin_reset_req}, 3'h5);
		i_fsp_host_model.wr(1'b0, 8'h02);
		check({quad_data_pins, write_protect_active, pause_active, pin_reset_req}, 4'h8);
		{wp_pin_n, pause_reset_pin_n} = 2'h3;
		i_fsp_host_model.cmd(8'h38);
		check(quad_command_mode, 1'b1);
		i_fsp_host_model.wr(1'b0, 8'h00);
		check(status_two, 8'h02);
		i_fsp_host_model.cmd(8'hFF);
		i_fsp_host_model.wr(1'b0, 8'h08);
		i_fsp_host_model.wr(1'b0, 8'h10);
		i_fsp_host_model.wr(1'b0, 8'h00);
		check(status_two, 8'h18);
		for (int i = 0; i < 4; i++)
			sec(i[1:0], i != 3);
		prot(1'b0, 1'b0, 1'b0, 3'h1, 'h1F0000, 'h1FFFFF);
		prot(1'b0, 1'b0, 1'b0, 3'h1, 'h1E0000, 'h1EFFFF);
		prot(1'b0, 1'b1, 1'b1, 3'h2, 'h1FFF, 'h2000);
		prot(1'b1, 1'b0, 1'b0, 3'h1, 'h1EFFFF, 'h1F0000);
		for (int i = 0; i < 60; i++)
		begin
			r = lfsr(r);
			f = r[26:6];
			l = f + (lfsr(r) & 'h3FFF);
			l = (l < f || l > 'h1FFFFF) ? 'h1FFFFF : l;
			prot(r[5], r[3], r[4], r[2:0], f, l);
		end
		protect_level = 3'h7;
		i_fsp_host_model.wr(1'b1, 8'h64);
		epc('h100000, 'h100FFF, 1'b1);
		strobe(4'h8, 21'h0);
		epc('h100000, 'h100FFF, 1'b0);
		strobe(4'h1, 21'h100000);
		epc('h100000, 'h100FFF, 1'b1);
		epc('h110000, 'h11FFFF, 1'b0);
		strobe(4'h2, 21'h100000);
		epc('h0FF000, 'h100FFF, 1'b0);
		strobe(4'h4, 21'h0);
		epc('h1FF000, 'h1FFFFF, 1'b1);
		end_of_test;
	end
endmodule : testbench
